// ### hw/sleep_mode_controller.sv
// sleep mode controller with an axi4-lite register slave
// assumes the cpu halts on o_gate.cpu_clk_en low; wake sources are levels
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller
  import sleep_ctrl_pkg::*;
#(
  parameter int osc_cycles = osc_startup_cycles
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // axi4-lite write
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // cpu, wake sources, brownout detector
  input wire logic i_sleep_instr,
  input wire logic i_debug_break,
  input wire wake_src_t i_wake,
  input wire logic i_custom_logic_needs_clk,
  input wire logic i_per_needs_main,
  input wire logic i_rtc_in_use,
  input wire logic [1:0] i_bod_active_mode,
  input wire logic i_bod_ready,
  // clock gating
  output gate_t o_gate,
  output logic o_resume
);

  typedef struct packed {
    slp_state_t st;
    logic [1:0] mode;
    logic main_off;
    logic [15:0] cnt;
    logic [7:0] ctrl;
    logic [n_stby-1:0] rstby;
    logic awh, wh, bv, rv;
    logic [3:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] rd;
    logic [1:0] bresp, rresp;
    gate_t gate;
    logic resume;
  } state_t;

  state_t q, d;
  logic [n_stby-1:0] stby_ok;
  logic wake_ev;
  logic [15:0] wake_len;

  for (genvar g = 0; g < n_stby; g++) begin : g_stby
    // custom logic wake in standby also needs run_in_standby
    assign stby_ok[g] = i_wake.stby[g] & q.rstby[g];
  end

  always_comb begin
    unique case (q.mode)
      idle_code: wake_ev = |i_wake;
      standby_code: wake_ev = i_wake.pin_or_ext | i_wake.twi_match |
        i_wake.periodic_interrupt_timer | (|stby_ok);
      default: wake_ev = i_wake.pin_or_ext | i_wake.periodic_interrupt_timer |
        i_wake.level_monitor | i_wake.twi_match |
        (i_wake.stby[custom_logic_idx] &
        ~i_custom_logic_needs_clk);
    endcase
  end

  assign wake_len = q.main_off ? 16'(wake_cycles + osc_cycles)
                               : 16'(wake_cycles);

  always_comb begin
    d = q;
    d.resume = 1'b0;
    // register write: address and data taken in either order
    if (!q.awh && i_awvalid) begin
      d.awh = 1'b1;
      d.awa = i_awaddr;
    end
    if (!q.wh && i_wvalid) begin
      d.wh = 1'b1;
      d.wd = i_wdata;
      d.ws = i_wstrb;
    end
    if (q.awh && q.wh && !q.bv) begin
      d.awh = 1'b0;
      d.wh = 1'b0;
      d.bv = 1'b1;
      d.bresp = 2'h0;
      if (q.awa == sleep_control_off) begin
        if (q.ws[0]) d.ctrl = q.wd[7:0] & sleep_control_wmask;
      end else if (q.awa == run_in_standby_off) begin
        if (q.ws[0]) d.rstby = q.wd[n_stby-1:0];
      end else if (q.awa != status_off) begin
        d.bresp = 2'h2;
      end
    end
    if (q.bv && i_bready) d.bv = 1'b0;
    if (!q.rv && i_arvalid) begin
      d.rv = 1'b1;
      d.rresp = 2'h0;
      d.rd = 32'h0;
      unique case (i_araddr)
        sleep_control_off: d.rd = {24'h0, q.ctrl};
        run_in_standby_off: d.rd = {26'h0, q.rstby};
        status_off: d.rd = {26'h0, q.mode, q.st};
        default: d.rresp = 2'h2;
      endcase
    end
    if (q.rv && i_rready) d.rv = 1'b0;

    unique case (q.st)
      st_active: begin
        if (i_sleep_instr && q.ctrl[sleep_enable_bit_pos]) begin
          d.st = st_sleep;
          d.mode = q.ctrl[sleep_mode_select_lsb +: 2];
          d.gate.cpu_clk_en = 1'b0;
          unique case (q.ctrl[sleep_mode_select_lsb +: 2])
            idle_code: d.main_off = 1'b0;
            standby_code: begin
              d.gate.per_clk_en = 1'b0;
              d.gate.unit_clk_en = q.rstby;
              d.gate.main_osc_en = i_per_needs_main;
              d.main_off = ~i_per_needs_main;
              d.gate.rtc_osc_en = q.rstby[0] | i_rtc_in_use;
            end
            default: begin
              d.gate.per_clk_en = 1'b0;
              d.gate.unit_clk_en = '0;
              d.gate.main_osc_en = 1'b0;
              d.gate.rtc_osc_en = i_rtc_in_use;
              d.main_off = 1'b1;
            end
          endcase
        end
      end
      st_sleep: begin
        if (wake_ev || i_debug_break) begin
          d.st = st_wake;
          d.cnt = 16'h0001;
          d.gate.per_clk_en = 1'b1;
          d.gate.unit_clk_en = '1;
          d.gate.main_osc_en = 1'b1;
          d.gate.rtc_osc_en = 1'b1;
        end
      end
      st_wake: begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt >= wake_len) begin
          if (i_bod_active_mode == bod_wait_code && !i_bod_ready) begin
            d.st = st_bodwt;
          end else begin
            d.st = st_active;
            d.gate.cpu_clk_en = 1'b1;
            d.resume = 1'b1;
          end
        end
      end
      st_bodwt: begin
        if (i_bod_ready) begin
          d.st = st_active;
          d.gate.cpu_clk_en = 1'b1;
          d.resume = 1'b1;
        end
      end
      default: d.st = st_active;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.st <= st_active;
      q.ctrl <= sleep_control_rst;
      q.rstby <= run_in_standby_rst;
      q.gate <= '1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_awready = ~q.awh;
  assign o_wready = ~q.wh;
  assign o_bvalid = q.bv;
  assign o_bresp = q.bresp;
  assign o_arready = ~q.rv;
  assign o_rvalid = q.rv;
  assign o_rdata = q.rd;
  assign o_rresp = q.rresp;
  assign o_gate = q.gate;
  assign o_resume = q.resume;

  // wake count measurement for checks
  logic [15:0] gated_cnt;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) gated_cnt <= 16'h0;
    else if (i_ce) gated_cnt <= (q.st == st_wake) ? gated_cnt + 16'h1 : 16'h0;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_enter_needs_en: assert property (
    i_ce && q.st == st_active && i_sleep_instr && !q.ctrl[0]
    |=> q.st == st_active) else $error("sleep entered without enable");
  a_cpu_gated: assert property (
    q.st != st_active |-> !q.gate.cpu_clk_en)
    else $error("cpu clock running while asleep");
  a_idle_per_on: assert property (
    q.st == st_sleep && q.mode == idle_code |-> q.gate.per_clk_en)
    else $error("idle stopped peripherals");
  a_pd_clocks_off: assert property (
    q.st == st_sleep && q.mode == power_down_code
    |-> !q.gate.per_clk_en && !q.gate.main_osc_en && q.gate.unit_clk_en == 0)
    else $error("power-down left clocks on");
  a_stby_gate: assert property (
    q.st == st_sleep && q.mode == standby_code
    |-> q.gate.unit_clk_en == q.rstby) else $error("standby gating wrong");
  a_break_wakes: assert property (
    i_ce && q.st == st_sleep && i_debug_break |=> q.st == st_wake)
    else $error("break did not wake");
  a_wake_min: assert property (
    q.st == st_wake && q.cnt < wake_len |=> q.st == st_wake)
    else $error("wake ended early");
  a_wake_len: assert property (
    $rose(q.resume) && $past(q.st) == st_wake |-> gated_cnt == wake_len)
    else $error("wake length wrong");
  a_bod_hold: assert property (
    q.st == st_bodwt && !i_bod_ready |=> !q.gate.cpu_clk_en)
    else $error("resumed before bod ready");

  c_idle: cover property (q.st == st_sleep && q.mode == idle_code);
  c_pd: cover property (q.st == st_sleep && q.mode == power_down_code);
  c_bod: cover property (q.st == st_bodwt);
  c_resume: cover property (q.resume);

endmodule : sleep_mode_controller
`default_nettype wire

// ### hw/sleep_ctrl_pkg.sv
// sleep controller package: register map, field layout, modes, timing
// assumes a single 50 MHz peripheral clock domain
package sleep_ctrl_pkg;

  localparam logic [3:0] sleep_control_off = 4'h0;
  localparam logic [3:0] run_in_standby_off = 4'h4;
  localparam logic [3:0] status_off = 4'h8;

  localparam int sleep_enable_bit_pos = 0;
  localparam int sleep_mode_select_lsb = 1;
  localparam logic [7:0] sleep_control_rst = 8'h00;
  localparam logic [7:0] sleep_control_wmask = 8'h07;
  localparam logic [5:0] run_in_standby_rst = 6'h00;

  localparam logic [1:0] idle_code = 2'h0;
  localparam logic [1:0] standby_code = 2'h1;
  localparam logic [1:0] power_down_code = 2'h2;
  localparam logic [1:0] bod_wait_code = 2'h3;

  localparam int wake_cycles = 6;
  localparam int osc_startup_ns = 2000;
  localparam int clk_period_ns = 20;
  localparam int osc_startup_cycles =
    (osc_startup_ns + clk_period_ns - 1) / clk_period_ns;

  // run-in-standby / wake index: rtc, uart sof, timer b, adc window, ac,
  // custom logic
  localparam int n_stby = 6;
  localparam int custom_logic_idx = 5;

  typedef enum logic [3:0] {
    st_active = 4'b0001,
    st_sleep  = 4'b0010,
    st_wake   = 4'b0100,
    st_bodwt  = 4'b1000
  } slp_state_t;

  typedef struct packed {
    logic [n_stby-1:0] stby;
    logic pin_or_ext;
    logic twi_match;
    logic periodic_interrupt_timer;
    logic level_monitor;
    logic other;
  } wake_src_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic per_clk_en;
    logic [n_stby-1:0] unit_clk_en;
    logic main_osc_en;
    logic rtc_osc_en;
  } gate_t;

endpackage : sleep_ctrl_pkg

// ### bench/cpu_side_model.sv
// cpu side: issues the sleep instruction and models brownout ready
// assumes go and armed change right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_go,
  input wire logic i_armed,
  input wire logic i_resume,
  input wire logic [7:0] i_bod_dly,
  output logic o_sleep_instr,
  output logic o_bod_ready
);
  logic asleep_q;
  logic [7:0] cnt_q;
  // ready drops in sleep so a slow detector really holds off the cpu
  assign o_bod_ready = !asleep_q || cnt_q >= i_bod_dly;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sleep_instr <= 1'b0;
      asleep_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      o_sleep_instr <= i_go;
      asleep_q <= (asleep_q | i_go) & !i_resume;
      cnt_q <= i_armed ? cnt_q + 8'h01 : 8'h00;
    end
  end
endmodule : cpu_side_model
`default_nettype wire

// ### bench/test_sleep_mode_controller.sv
// self-checking bench for the sleep mode controller
// assumes registered bus readies, sampled one half cycle before the edge
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module test_sleep_mode_controller;
  import sleep_ctrl_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [3:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_v;
  logic awr, wr_r, bv, arr, rv, resume, slp, bod_rdy, go = 0, armed = 0;
  logic dbg = 0, logic_clk = 0, needs_main = 0, rtc_use = 0;
  logic [1:0] bresp, rresp, bod_mode = 0, resp;
  logic [31:0] rdat;
  logic [7:0] bod_dly = 0;
  wake_src_t wake = '0;
  gate_t gate;
  int miscompares = 0, check_count = 0;
  logic [10:0] pd_src [8] = '{11'h001, 11'h002, 11'h004, 11'h008,
    11'h010, 11'h020, 11'h400, 11'h400};
  logic [5:0] rs;
  logic [31:0] ctrl_w;
  sleep_mode_controller #(.osc_cycles(4)) i_sleep_mode_controller (
    .i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'h1),
    .i_wvalid(wv), .o_wready(wr_r), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(br), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr),
    .i_sleep_instr(slp), .i_debug_break(dbg), .i_wake(wake),
    .i_custom_logic_needs_clk(logic_clk), .i_per_needs_main(needs_main),
    .i_rtc_in_use(rtc_use), .i_bod_active_mode(bod_mode),
    .i_bod_ready(bod_rdy), .o_gate(gate), .o_resume(resume));
  cpu_side_model i_cpu_side_model (.i_clk(clk), .i_sys_rst(rst),
    .i_go(go), .i_armed(armed), .i_resume(resume), .i_bod_dly(bod_dly),
    .o_sleep_instr(slp), .o_bod_ready(bod_rdy));
  initial forever #10 clk = ~clk;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ah, dh, ad, dd, b;
    ad = 0; dd = 0;
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    while (!(ad && dd)) begin
      @(negedge clk); ah = awr & awv; dh = wr_r & wv;
      @(posedge clk);
      if (ah) begin awv <= 0; ad = 1; end
      if (dh) begin wv <= 0; dd = 1; end
    end
    do begin @(negedge clk); b = bv; resp = bresp; @(posedge clk); end
    while (!b);
    br <= 0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    logic ah, r;
    ara <= a; arv <= 1; rr <= 1;
    do begin @(negedge clk); ah = arr; @(posedge clk); end while (!ah);
    arv <= 0;
    do begin
      @(negedge clk);
      r = rv;
      rd_v = rdat;
      resp = rresp;
      @(posedge clk);
    end while (!r);
    rr <= 0;
    @(posedge clk);
  endtask : rd
  task automatic sleep_in(input logic [1:0] m, input logic [5:0] r);
    wr(4'h4, {26'h0, r});
    wr(4'h0, {29'h0, m, 1'b1});
    go <= 1;
    @(posedge clk) go <= 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `chk("cpu_gated", 1'b0, gate.cpu_clk_en)
  endtask : sleep_in
  // counts edges from the wake request to the resume pulse
  task automatic wait_resume(input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clk) armed <= 1;
    do begin @(negedge clk); n++; end while (!resume && n < 400);
    `chk("wake_time", 1'b1, 1'(n >= lo && n <= hi))
    @(posedge clk) begin wake <= '0; dbg <= 0; armed <= 0; end
    @(posedge clk);
  endtask : wait_resume
  task automatic no_wake(input int x);
    repeat (20) @(negedge clk);
    `chk("no_wake", 1'b0, gate.cpu_clk_en)
    @(posedge clk) dbg <= 1;
    wait_resume(6 + x, 9 + x);
  endtask : no_wake
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(93241));
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(4'h0);
    `chk("ctrl_rst", 32'h0, rd_v)
    `chk("rd_resp", 2'h0, resp)
    rd(4'h8);
    `chk("status_rst", 32'h1, rd_v)
    rd(4'hc);
    `chk("rd_unmapped", 2'h2, resp)
    // the reserved mode code must never be written
    ctrl_w = $urandom;
    if (ctrl_w[2:1] == 2'h3) ctrl_w[2] = 1'b0;
    wr(4'h0, ctrl_w);
    `chk("ok_resp", 2'h0, resp)
    rd(4'h0);
    `chk("ctrl_rdback", ctrl_w & 32'h7, rd_v)
    wr(4'h0, 32'h0);
    wr(4'hc, 32'h1);
    `chk("unmapped", 2'h2, resp)
    go <= 1;
    @(posedge clk) go <= 0;
    repeat (4) @(negedge clk);
    `chk("no_enable", 1'b1, gate.cpu_clk_en)
    sleep_in(idle_code, 6'($urandom));
    `chk("idle_per", 1'b1, gate.per_clk_en)
    `chk("idle_osc", 1'b1, gate.main_osc_en)
    @(posedge clk) wake.other <= 1;
    wait_resume(6, 9);
    needs_main <= 1;
    for (int i = 0; i < 6; i++) begin
      rs = 6'($urandom);
      rs[i] = i[0];
      sleep_in(standby_code, rs);
      `chk("stby_units", rs, gate.unit_clk_en)
      `chk("stby_osc", 1'b1, gate.main_osc_en)
      @(posedge clk) wake.stby[i] <= 1;
      if (rs[i]) wait_resume(6, 9);
      else no_wake(0);
    end
    needs_main <= 0;
    for (int k = 0; k < 8; k++) begin
      logic_clk <= (k == 6);
      rtc_use <= 1'($urandom);
      sleep_in(power_down_code, 6'h3f);
      `chk("pd_per", 1'b0, gate.per_clk_en)
      `chk("pd_units", 6'h00, gate.unit_clk_en)
      `chk("pd_osc", 1'b0, gate.main_osc_en)
      `chk("pd_rtc", rtc_use, gate.rtc_osc_en)
      @(posedge clk) wake <= pd_src[k];
      if (k inside {1, 2, 3, 4, 7}) wait_resume(10, 14);
      else no_wake(4);
    end
    bod_mode <= 2'h3;
    bod_dly <= 8'h14;
    sleep_in(idle_code, 6'h0);
    @(posedge clk) wake.other <= 1;
    wait_resume(20, 25);
    bod_mode <= 2'h0;
    sleep_in(power_down_code, 6'h0);
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    @(negedge clk);
    `chk("rst_wake", 1'b1, gate.cpu_clk_en)
    @(posedge clk);
    rd(4'h0);
    `chk("rst_ctrl", 32'h0, rd_v)
    summarize();
  end
endmodule : test_sleep_mode_controller
`default_nettype wire
